//--- design/wake_consts.vh
// constants shared by the standby wake request detect block
`ifndef WAKE_CONSTS_VH
`define WAKE_CONSTS_VH

`define WAKE_NUM_CH        6
`define WAKE_ADDR_W        8

`define OFF_MODE_CH0_3     8'h00
`define OFF_MODE_CH4_5     8'h04
`define OFF_REQ_CLEAR      8'h08
`define OFF_PEND_STATUS    8'h0C

`define FLD_EN_BIT         0
`define FLD_ST_LSB         2
`define FLD_ST_W           2
`define FLD_MODE_LSB       4
`define FLD_MODE_W         3
`define FLD_CLR_IDX_W      5

`define MODE_LOW_LEVEL     3'h0
`define MODE_HIGH_LEVEL    3'h1
`define MODE_FALL_EDGE     3'h2
`define MODE_RISE_EDGE     3'h3
`define MODE_BOTH_EDGE     3'h4
`define MODE_RESET         3'h2

`define ST_NONE            2'h0
`define ST_RISE            2'h1
`define ST_FALL            2'h2

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

//--- design/wake_chan_detect.v
// one wake channel: pin synchroniser, condition detector, pending flag and edge status
`timescale 1ns/1ps
`include "wake_consts.vh"

module wake_chan_detect (
  input  wire       clk,
  input  wire       rstn,
  input  wire       pin,
  input  wire [2:0] mode,
  input  wire       enable,
  input  wire       clear,
  output reg        pend_ff,
  output reg  [1:0] status_ff
);

  reg        s1_ff;
  reg        s2_ff;
  reg        s3_ff;
  reg        filt_ff;
  reg        hit;
  reg  [1:0] nxt_status;
  wire       agree;
  wire       rise;
  wire       fall;

  // a pin change counts only once the second and third stage agree
  assign agree = (s2_ff == s3_ff);
  assign rise  = agree & s2_ff & ~filt_ff;
  assign fall  = agree & ~s2_ff & filt_ff;

  always @* begin
    case (mode)
      `MODE_LOW_LEVEL:  hit = ~filt_ff;              // see R1
      `MODE_HIGH_LEVEL: hit = filt_ff;               // see R1
      `MODE_FALL_EDGE:  hit = fall;                  // see R2
      `MODE_RISE_EDGE:  hit = rise;                  // see R2
      `MODE_BOTH_EDGE:  hit = rise | fall;           // see R2
      default:          hit = 1'b0;                  // see R3
    endcase
  end

  always @* begin
    nxt_status = clear ? `ST_NONE : status_ff;       // see R7
    // status only tracks edges in both-edge mode, elsewhere only a clear changes it
    if (enable && (mode == `MODE_BOTH_EDGE)) begin   // see R6
      nxt_status = nxt_status | {fall, rise};        // see R4
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff     <= 1'b0;
      s2_ff     <= 1'b0;
      s3_ff     <= 1'b0;
      filt_ff   <= 1'b0;
      pend_ff   <= 1'b0;
      status_ff <= `ST_NONE;                         // see R10
    end else begin
      s1_ff     <= pin;
      s2_ff     <= s1_ff;
      s3_ff     <= s2_ff;
      if (agree) begin
        filt_ff <= s2_ff;
      end
      // a new request in the clearing cycle wins over the clear
      pend_ff   <= (enable & hit) | (pend_ff & ~clear); // see R5
      status_ff <= nxt_status;
    end
  end

endmodule

//--- design/standby_wake_request_detect.v
// standby wake request detect: six pin channels behind an AXI4-Lite register slave
//
// Summary of operation
// R1: mode 000 low level, 001 high level
// R2: mode 010 fall, 011 rise, 100 both
// R3: software never programs modes 101 to 111
// R4: edge status 01 rise, 10 fall, 11 both
// R5: channel enable gates wake request generation
// R6: edge status meaningful only in both-edge mode
// R7: request clear also clears edge status
// R8: software writes mode before enable, separately
// R9: ch0-3 bytes of reg A, ch4-5 reg B
// R10: reset mode 010, enable 0, status 00
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "wake_consts.vh"

module standby_wake_request_detect #(
  parameter NUM_CH = `WAKE_NUM_CH,
  parameter ADDR_W = `WAKE_ADDR_W
) (
  input  wire              CLK,
  input  wire              RSTN,
  input  wire [NUM_CH-1:0] WAKE_IN,
  output reg  [NUM_CH-1:0] WAKE_PEND,
  output reg               WAKE_REQ,
  input  wire [ADDR_W-1:0] AWADDR,
  input  wire [2:0]        AWPROT,
  input  wire              AWVALID,
  output reg               AWREADY,
  input  wire [31:0]       WDATA,
  input  wire [3:0]        WSTRB,
  input  wire              WVALID,
  output reg               WREADY,
  output reg  [1:0]        BRESP,
  output reg               BVALID,
  input  wire              BREADY,
  input  wire [ADDR_W-1:0] ARADDR,
  input  wire [2:0]        ARPROT,
  input  wire              ARVALID,
  output reg               ARREADY,
  output reg  [31:0]       RDATA,
  output reg  [1:0]        RRESP,
  output reg               RVALID,
  input  wire              RREADY
);

  // write channel holding registers
  reg                 aw_have_ff;
  reg                 w_have_ff;
  reg  [ADDR_W-1:0]   waddr_ff;
  reg  [31:0]         wdata_ff;
  reg  [3:0]          wstrb_ff;

  // per channel configuration
  reg  [3*NUM_CH-1:0] mode_ff;
  reg  [NUM_CH-1:0]   en_ff;

  wire [2*NUM_CH-1:0] status;
  wire [NUM_CH-1:0]   pend;
  wire [NUM_CH-1:0]   clr;
  wire [8*NUM_CH-1:0] chan_byte;
  wire [63:0]         chan_bytes_ext;

  wire                do_write;
  wire                wr_hit_a;
  wire                wr_hit_b;
  wire                wr_hit_clr;
  wire [31:0]         word_a;
  wire [31:0]         word_b;
  wire [31:0]         word_pend;

  reg  [31:0]         nxt_rdata;
  reg  [1:0]          nxt_rresp;
  reg  [1:0]          nxt_bresp;

  // the write commits only once both address and data are held and no response is pending
  assign do_write   = aw_have_ff & w_have_ff & ~BVALID;
  // byte offsets are word aligned, so the two low address bits are ignored
  assign wr_hit_a   = ({waddr_ff[ADDR_W-1:2], 2'b00} == `OFF_MODE_CH0_3);
  assign wr_hit_b   = ({waddr_ff[ADDR_W-1:2], 2'b00} == `OFF_MODE_CH4_5);
  assign wr_hit_clr = ({waddr_ff[ADDR_W-1:2], 2'b00} == `OFF_REQ_CLEAR);

  // AXI write address, data and response channels
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      waddr_ff   <= {ADDR_W{1'b0}};
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      AWREADY    <= 1'b1;
      WREADY     <= 1'b1;
      BVALID     <= 1'b0;
      BRESP      <= `RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_have_ff <= 1'b1;
        waddr_ff   <= AWADDR;
        AWREADY    <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_have_ff <= 1'b1;
        wdata_ff  <= WDATA;
        wstrb_ff  <= WSTRB;
        WREADY    <= 1'b0;
      end
      if (do_write) begin
        aw_have_ff <= 1'b0;
        w_have_ff  <= 1'b0;
        BVALID     <= 1'b1;
        BRESP      <= nxt_bresp;
      end
      if (BVALID && BREADY) begin
        BVALID  <= 1'b0;
        AWREADY <= 1'b1;
        WREADY  <= 1'b1;
      end
    end
  end

  always @* begin
    if (wr_hit_a || wr_hit_b || wr_hit_clr) begin
      nxt_bresp = `RESP_OKAY;
    end else if ({waddr_ff[ADDR_W-1:2], 2'b00} == `OFF_PEND_STATUS) begin
      // read-only register: the write is accepted and dropped
      nxt_bresp = `RESP_OKAY;
    end else begin
      nxt_bresp = `RESP_SLVERR;
    end
  end

  // per channel: config fields, read byte, clear decode and detector
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c = c + 1) begin : g_ch
      localparam LANE  = c % 4;
      localparam IN_A  = (c < 4);
      localparam [`FLD_CLR_IDX_W-1:0] IDX = c;
      wire       hit_reg;
      wire       lane_on;

      assign hit_reg = IN_A ? wr_hit_a : wr_hit_b;                  // see R9
      assign lane_on = wstrb_ff[LANE];

      always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          mode_ff[3*c +: 3] <= `MODE_RESET;                         // see R10
          en_ff[c]          <= 1'b0;                                // see R10
        end else if (do_write && hit_reg && lane_on) begin
          mode_ff[3*c +: 3] <= wdata_ff[8*LANE + `FLD_MODE_LSB +: 3]; // see R9
          en_ff[c]          <= wdata_ff[8*LANE + `FLD_EN_BIT];      // see R5
        end
      end

      assign clr[c] = do_write & wr_hit_clr & wstrb_ff[0] &
                      (wdata_ff[`FLD_CLR_IDX_W-1:0] == IDX);        // see R7

      // bit 1 and bit 7 of each byte read as zero
      assign chan_byte[8*c +: 8] = {1'b0, mode_ff[3*c +: 3], status[2*c +: 2],
                                    1'b0, en_ff[c]};                // see R9

      wake_chan_detect u_det (
        .clk       (CLK),
        .rstn      (RSTN),
        .pin       (WAKE_IN[c]),
        .mode      (mode_ff[3*c +: 3]),
        .enable    (en_ff[c]),
        .clear     (clr[c]),
        .pend_ff   (pend[c]),
        .status_ff (status[2*c +: 2])
      );
    end
  endgenerate

  // unimplemented channel lanes of the second register read as zero
  assign chan_bytes_ext = {{(64-8*NUM_CH){1'b0}}, chan_byte};
  assign word_a         = chan_bytes_ext[31:0];                     // see R9
  assign word_b         = {16'h0000, chan_bytes_ext[47:32]};        // see R9
  assign word_pend      = {{(32-NUM_CH){1'b0}}, pend};

  always @* begin
    nxt_rresp = `RESP_OKAY;
    case ({ARADDR[ADDR_W-1:2], 2'b00})
      `OFF_MODE_CH0_3:  nxt_rdata = word_a;
      `OFF_MODE_CH4_5:  nxt_rdata = word_b;
      `OFF_REQ_CLEAR:   nxt_rdata = 32'h00000000;
      `OFF_PEND_STATUS: nxt_rdata = word_pend;
      default: begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = `RESP_SLVERR;
      end
    endcase
  end

  // AXI read address and data channels
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= `RESP_OKAY;
    end else begin
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
        RVALID  <= 1'b1;
        RDATA   <= nxt_rdata;
        RRESP   <= nxt_rresp;
      end
      if (RVALID && RREADY) begin
        RVALID  <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

  // outputs re-registered so that they come straight from flip-flops
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      WAKE_PEND <= {NUM_CH{1'b0}};
      WAKE_REQ  <= 1'b0;
    end else begin
      WAKE_PEND <= pend;                                            // see R5
      WAKE_REQ  <= |pend;
    end
  end

endmodule

//--- sim/wake_pins_model.sv
// far-side model: external wake request pins
`timescale 1ns/1ps
module wake_pins_model (
  output logic [5:0] pins
);
  initial pins = 6'h00;
  // sources hold a level until told otherwise, as a real request line does
  task automatic set_pin(input int c, input logic v);
    pins[c] <= v;
  endtask
endmodule

//--- sim/wake_detect_chk.sv
// concurrent checks on the wake detect block's bus and pending outputs
`timescale 1ns/1ps
`include "wake_consts.vh"
module wake_chk #(
  parameter NUM_CH = 6
) (
  input wire              CLK,
  input wire              RSTN,
  input wire [NUM_CH-1:0] WAKE_PEND,
  input wire              WAKE_REQ,
  input wire              AWVALID,
  input wire              AWREADY,
  input wire              WVALID,
  input wire              WREADY,
  input wire              BVALID,
  input wire              BREADY,
  input wire              ARVALID,
  input wire              ARREADY,
  input wire              RVALID,
  input wire              RREADY,
  input wire [31:0]       RDATA,
  input wire [1:0]        RRESP
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence ar_hs;
    ARVALID && ARREADY;
  endsequence
  sequence r_done;
    !RVALID && ARREADY;
  endsequence
  sequence wr_hs;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  req_or_a: assert property (WAKE_REQ == |WAKE_PEND)
    else $error("wake request differs from OR of pending");
  rd_walk_a: assert property (ar_hs ##1 RREADY |-> RVALID && !ARREADY ##1 r_done)
    else $error("read handshake sequence broken");
  wr_walk_a: assert property (wr_hs |=> !AWREADY && !BVALID ##1 BVALID && !AWREADY)
    else $error("write response not two edges after handshake");
  b_done_a: assert property (BVALID && BREADY |=> !BVALID && AWREADY)
    else $error("write response not retired");
  aw_busy_a: assert property (BVALID |-> !AWREADY)
    else $error("address accepted while response pending");
  slverr_zero_a: assert property (RVALID && RRESP == `RESP_SLVERR |-> RDATA == 32'h0)
    else $error("error read returned data");
  pend_drop_a: assert property (|($past(WAKE_PEND) & ~WAKE_PEND) |-> $past(BVALID))
    else $error("pending dropped without a clear write");
  reset_vals_a: assert property ($rose(RSTN) |-> AWREADY && ARREADY && !BVALID && !WAKE_REQ)
    else $error("outputs wrong after reset");
endmodule

bind standby_wake_request_detect wake_chk #(.NUM_CH(NUM_CH)) u_chk (
  .CLK(CLK), .RSTN(RSTN), .WAKE_PEND(WAKE_PEND), .WAKE_REQ(WAKE_REQ), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
  .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP));

//--- sim/tb.sv
// self-checking bench for the standby wake request detect block
`timescale 1ns/1ps
`include "wake_consts.vh"
module tb;
  logic        clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        bready = 1'b1, rready = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  wire  [5:0]  pins, pend;
  wire  [31:0] rdata;
  wire  [1:0]  bresp, rresp;
  wire         req, awready, wready, bvalid, arready, rvalid;
  logic [33:0] q[$];
  logic [7:0]  sh[6];
  int          num_errors = 0, cmp_count = 0;

  standby_wake_request_detect i_dut (.CLK(clk), .RSTN(rstn), .WAKE_IN(pins), .WAKE_PEND(pend),
    .WAKE_REQ(req), .AWADDR(awaddr), .AWPROT(3'h0), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARPROT(3'h0), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
  wake_pins_model i_pins (.pins(pins));

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic end_sim;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input [33:0] got);
    logic [33:0] e;
    e = q.pop_front();
    cmp_count++;
    if (got !== e) begin
      num_errors++;
      $display("[FAIL] %0t exp %h got %h", $time, e, got);
    end
  endtask

  // ready lines stay high, so every answer is retired at the edge it shows
  always @(posedge clk) begin
    if (bvalid && bready)
      chk({bresp, 32'h0});
    if (rvalid && rready)
      chk({rresp, rdata});
  end

  task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] r);
    logic aw, w;
    q.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    while (!(aw && w)) begin
      @(posedge clk);
      aw = aw | awready;
      w = w | wready;
      awvalid <= !aw;
      wvalid <= !w;
    end
    do @(posedge clk); while (!bvalid);
  endtask

  task automatic rd(input [7:0] a, input [33:0] e);
    q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
  endtask

  // the pin outputs must show the same picture as the pending register
  task automatic pend_chk(input [5:0] e);
    cmp_count++;
    if (pend !== e || req !== |e) begin
      num_errors++;
      $display("[FAIL] %0t exp %h got %h", $time, {|e, e}, {req, pend});
    end
  endtask

  function automatic [33:0] regw(input int b);
    regw = b ? {18'h0, sh[5], sh[4]} : {2'h0, sh[3], sh[2], sh[1], sh[0]};
  endfunction

  // random filler in unstrobed lanes proves the other channels are untouched
  task automatic set_ch(input int c, input [7:0] v);
    logic [31:0] d;
    sh[c] = v;
    d = $urandom;
    d[8*(c%4) +: 8] = v;
    if (c >= 4) d[31:16] = 16'h0000;
    wr(c < 4 ? 8'h00 : 8'h04, d, 4'h1 << (c % 4), `RESP_OKAY);
  endtask

  // eight cycles covers the synchroniser and pending register delay
  task automatic pin_wait(input int c, input logic v);
    i_pins.set_pin(c, v);
    repeat (8) @(posedge clk);
  endtask

  initial begin
    int   m;
    logic s;
    foreach (sh[i]) sh[i] = 8'h20;
    void'($urandom(32'h2EC7));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(8'h00, regw(0));
    rd(8'h04, regw(1));
    rd(8'h10, {`RESP_SLVERR, 32'h0});
    wr(8'h10, 32'h0, 4'hF, `RESP_SLVERR);
    wr(8'h0C, 32'h3F, 4'hF, `RESP_OKAY);
    rd(8'h0C, 34'h0);
    pend_chk(6'h00);
    for (int c = 0; c < 6; c++) begin
      m = (c < 5) ? c : 4;
      // channel 5 sees its falling edge first, so both single-edge codes show up
      s = (m == 0 || m == 2 || c == 5);
      set_ch(c, {1'b0, m[2:0], 4'h0});
      pin_wait(c, !s);
      rd(8'h0C, 34'h0);
      pend_chk(6'h00);
      pin_wait(c, s);
      set_ch(c, {1'b0, m[2:0], 4'h1});
      pin_wait(c, !s);
      rd(8'h0C, 34'h1 << c);
      pend_chk(6'h01 << c);
      if (m == 4) begin
        sh[c] = sh[c] | (s ? 8'h08 : 8'h04);
        rd(c < 4 ? 8'h00 : 8'h04, regw(c / 4));
      end
      pin_wait(c, s);
      if (m == 4) begin
        sh[c] = sh[c] | 8'h0C;
        rd(c < 4 ? 8'h00 : 8'h04, regw(c / 4));
      end
      wr(8'h08, c, 4'hF, `RESP_OKAY);
      sh[c] = sh[c] & 8'hF3;
      rd(c < 4 ? 8'h00 : 8'h04, regw(c / 4));
      rd(8'h0C, 34'h0);
      pend_chk(6'h00);
    end
    // a reset in mid-run puts every channel back to its idle setup
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (sh[i]) sh[i] = 8'h20;
    rd(8'h00, regw(0));
    rd(8'h04, regw(1));
    rd(8'h0C, 34'h0);
    pend_chk(6'h00);
    end_sim();
  end

  // the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end
endmodule
